// ===== core/uart_regs.svh
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define UART_ADDR_STATUS  3'h0
`define UART_ADDR_TXBYTE  3'h1
`define UART_ADDR_RXBYTE  3'h2
`define UART_ADDR_FORMAT  3'h3
`define UART_ADDR_CONTROL 3'h4

// ----------------------------------------------------------------
// line_status_register bit positions
// ----------------------------------------------------------------
`define ST_TX_EMPTY  0
`define ST_RX_AVAIL  1
`define ST_TX_BUSY   2
`define ST_RX_FULL   3
`define ST_OVERRUN   4
`define ST_PAR_ERR   5
`define ST_FRM_ERR   6
`define ST_TX_DONE   7

// ----------------------------------------------------------------
// frame_format_register and line_control_register bit positions
// ----------------------------------------------------------------
`define FMT_STOP_LEN 0
`define FMT_PAR_ODD  1
`define FMT_PAR_EN   2
`define FMT_CHAR_LEN 3
`define CTL_ENABLE   0
`define CTL_RX_THR   1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UART_FORMAT_RESET  4'h0
`define UART_CONTROL_RESET 2'h0
`define UART_ENABLE_RESET  1'b0
`define UART_THRESH_RESET  1'b0

// ----------------------------------------------------------------
// timing counts in oversample ticks and clock cycles
// ----------------------------------------------------------------
`define UART_TICK_LAST  4'hf
`define UART_TICK_MID   4'h7
`define UART_TICK16_DIV 8'h05

`endif

// ===== core/uart_pkg.sv
package uart_pkg;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE   = 5'b00001,
    TX_START  = 5'b00010,
    TX_DATA   = 5'b00100,
    TX_PARITY = 5'b01000,
    TX_STOP   = 5'b10000
  } tx_state_type;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP   = 5'b10000
  } rx_state_type;

  // parity of a byte: 1 when it holds an odd number of ones
  function automatic logic ones_odd(input logic [7:0] data);
    return ^data;
  endfunction

endpackage

// ===== core/uart_rx_frame.sv
`include "uart_regs.svh"

// receive framing: start detect, data, parity and first stop sample
module uart_rx_frame (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_tick16,   // oversample enable
  input  wire logic       i_enable,   // transfer enable
  input  wire logic       i_rxd,      // synchronised line level
  input  wire logic       i_eight,    // 8-bit characters
  input  wire logic       i_par_en,   // parity present
  input  wire logic       i_par_odd,  // odd sense
  output logic            o_done,     // one-cycle pulse, frame complete
  output logic [7:0]      o_data,     // received byte
  output logic            o_par_err,  // parity mismatch for o_data
  output logic            o_frm_err   // first stop bit was low
);

  uart_pkg::rx_state_type state_q;    // framing state
  logic [3:0]             phase_q;    // oversample phase in the bit
  logic [2:0]             idx_q;      // next data bit index
  logic [7:0]             shift_q;    // receive shift register
  logic                   perr_q;     // parity result
  logic                   ferr_q;     // stop result
  logic                   done_q;     // completion pulse
  logic                   armed_q;    // line seen idle since the last frame

  wire [2:0] last_idx = i_eight ? 3'h7 : 3'h6;
  wire       bit_mid  = (phase_q == `UART_TICK_LAST);

  // ----------------------------------------------------------------
  // framing sequencer, samples one tick per bit centre
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= uart_pkg::RX_IDLE;
      phase_q <= 4'h0;
      idx_q   <= 3'h0;
      shift_q <= 8'h00;
      perr_q  <= 1'b0;
      ferr_q  <= 1'b0;
      done_q  <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!i_enable) begin
        state_q <= uart_pkg::RX_IDLE;
      end else if (i_tick16) begin
        phase_q <= phase_q + 4'h1;
        case (state_q)
          uart_pkg::RX_IDLE: begin
            // low level starts a frame once the line was idle
            // a low first stop bit must not read as the next start
            if (!i_rxd && armed_q) begin
              state_q <= uart_pkg::RX_START;
              phase_q <= 4'h1;
              armed_q <= 1'b0;
            end else if (i_rxd) begin
              armed_q <= 1'b1;
            end
          end
          uart_pkg::RX_START: begin
            // recheck at the bit centre so a glitch is not a start
            if (phase_q == `UART_TICK_MID) begin
              state_q <= i_rxd ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
              phase_q <= 4'h0;
              idx_q   <= 3'h0;
              shift_q <= 8'h00;
              perr_q  <= 1'b0;
            end
          end
          uart_pkg::RX_DATA: begin
            if (bit_mid) begin
              shift_q[idx_q] <= i_rxd;  // first bit lands in the lsb
              idx_q          <= idx_q + 3'h1;
              if (idx_q == last_idx) begin
                state_q <= i_par_en ? uart_pkg::RX_PARITY : uart_pkg::RX_STOP;
              end
            end
          end
          uart_pkg::RX_PARITY: begin
            if (bit_mid) begin
              // bit right after the msb is checked
              perr_q  <= uart_pkg::ones_odd(shift_q) ^ i_rxd ^ i_par_odd;
              state_q <= uart_pkg::RX_STOP;
            end
          end
          uart_pkg::RX_STOP: begin
            if (bit_mid) begin
              ferr_q  <= !i_rxd;          // only the first stop bit
              done_q  <= 1'b1;
              state_q <= uart_pkg::RX_IDLE;
            end
          end
          default: state_q <= uart_pkg::RX_IDLE;
        endcase
      end
    end
  end

  assign o_done    = done_q;
  assign o_data    = shift_q;
  assign o_par_err = perr_q;
  assign o_frm_err = ferr_q;

endmodule

// ===== core/uart_core.sv
`include "uart_regs.svh"

module uart_core #(
  parameter logic [7:0] TICK16_DIV = `UART_TICK16_DIV  // clocks per oversample tick
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [2:0] i_addr,       // register offset
  input  wire logic [7:0] i_wdata,      // write data
  input  wire logic       i_wr,         // write strobe
  input  wire logic       i_rd,         // read strobe
  output logic      [7:0] o_rdata,      // read data, cycle after i_rd
  input  wire logic       i_serial_in,  // receive pin, asynchronous
  output logic            o_serial_out_pin,
  output logic            o_rx_level    // queue full with rx_irq_threshold_bit set, else queue not empty
);

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire wr_status  = i_wr && (i_addr == `UART_ADDR_STATUS);
  wire wr_txbyte  = i_wr && (i_addr == `UART_ADDR_TXBYTE);
  wire wr_format  = i_wr && (i_addr == `UART_ADDR_FORMAT);
  wire wr_control = i_wr && (i_addr == `UART_ADDR_CONTROL);
  wire rd_rxbyte  = i_rd && (i_addr == `UART_ADDR_RXBYTE);

  // ----------------------------------------------------------------
  // control and format state
  // ----------------------------------------------------------------
  logic       en_q;        // transfer_enable_bit
  logic       rx_irq_threshold_bit_q;      // rx_irq_threshold_bit
  logic [3:0] fmt_q;       // frame_format_register

  wire eight     = fmt_q[`FMT_CHAR_LEN];  // char_length_bit
  wire par_en    = fmt_q[`FMT_PAR_EN];    // parity_enable_bit
  wire par_odd   = fmt_q[`FMT_PAR_ODD];   // parity_sense_bit
  wire two_stop  = fmt_q[`FMT_STOP_LEN];  // stop_length_bit
  wire en_d      = wr_control ? i_wdata[`CTL_ENABLE] : en_q;
  wire rx_irq_threshold_bit_d    = wr_control ? i_wdata[`CTL_RX_THR] : rx_irq_threshold_bit_q;
  wire flush     = wr_control && !i_wdata[`CTL_ENABLE];

  // settings are plain storage; software changes them while disabled
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_q   <= `UART_ENABLE_RESET;
      rx_irq_threshold_bit_q <= `UART_THRESH_RESET;
      fmt_q  <= `UART_FORMAT_RESET;
    end else begin
      en_q   <= en_d;
      rx_irq_threshold_bit_q <= rx_irq_threshold_bit_d;
      if (wr_format) begin
        fmt_q <= i_wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // oversample enable divider and transmit bit phase
  // ----------------------------------------------------------------
  logic [7:0] div_q;       // clock divider
  logic       tick16_q;    // one-cycle oversample enable
  logic [3:0] phase16_q;   // ticks within one transmit bit

  wire bit_tick = tick16_q && (phase16_q == `UART_TICK_LAST);

  // the divider free-runs so the bit grid never depends on traffic
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q     <= 8'h00;
      tick16_q  <= 1'b0;
      phase16_q <= 4'h0;
    end else begin
      tick16_q <= (div_q == TICK16_DIV - 8'h01);
      div_q    <= (div_q == TICK16_DIV - 8'h01) ? 8'h00 : div_q + 8'h01;
      if (tick16_q) begin
        phase16_q <= phase16_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer and shifter
  // ----------------------------------------------------------------
  uart_pkg::tx_state_type tx_state_q;  // transmit sequencer
  logic [7:0] buf_q;       // one-byte transmit buffer
  logic       tx_buffer_empty_flag_q;      // tx_buffer_empty_flag
  logic       tx_shift_busy_flag_q;      // tx_shift_busy_flag
  logic       tx_done_flag_q;      // tx_done_flag
  logic [7:0] tx_shift_q;  // transmit shift register
  logic [2:0] tx_idx_q;    // data bit or stop bit count
  logic       tx_par_q;    // parity bit for this frame
  logic       serial_q;    // serial_out_pin level

  wire [2:0] last_idx = eight ? 3'h7 : 3'h6;
  wire [2:0] n_stop   = two_stop ? 3'h2 : 3'h1;
  wire [7:0] buf_data = eight ? buf_q : {1'b0, buf_q[6:0]};
  wire tx_load  = en_q && !tx_buffer_empty_flag_q && (tx_state_q == uart_pkg::TX_IDLE);
  wire tx_end   = (tx_state_q == uart_pkg::TX_STOP) && bit_tick && (tx_idx_q == n_stop);
  wire tx_shift_busy_flag_clr = tx_shift_busy_flag_q && (tx_end || !en_q);
  wire clr_tx_done_flag = wr_status && i_wdata[`ST_TX_DONE];

  // buffer flags; a write beside a load keeps the new byte waiting
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_q  <= 8'h00;
      tx_buffer_empty_flag_q <= 1'b1;
      tx_done_flag_q <= 1'b0;
    end else begin
      if (wr_txbyte) begin
        buf_q <= i_wdata;             // overwrites a waiting byte
      end
      if (flush) begin
        tx_buffer_empty_flag_q <= 1'b1;
      end else if (wr_txbyte) begin
        tx_buffer_empty_flag_q <= 1'b0;
      end else if (tx_load) begin
        tx_buffer_empty_flag_q <= 1'b1;
      end
      if (tx_shift_busy_flag_clr) begin
        tx_done_flag_q <= 1'b1;               // set wins over clear
      end else if (clr_tx_done_flag) begin
        tx_done_flag_q <= 1'b0;
      end
    end
  end

  // frame sequencer: start, data lsb first, parity, stop bits
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_state_q <= uart_pkg::TX_IDLE;
      tx_shift_busy_flag_q     <= 1'b0;
      tx_shift_q <= 8'h00;
      tx_idx_q   <= 3'h0;
      tx_par_q   <= 1'b0;
      serial_q   <= 1'b1;
    end else if (!en_q) begin
      // disabling abandons a frame in flight; the line returns idle
      tx_state_q <= uart_pkg::TX_IDLE;
      tx_shift_busy_flag_q     <= 1'b0;
      serial_q   <= 1'b1;
    end else begin
      case (tx_state_q)
        uart_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_shift_q <= buf_data;
            tx_par_q   <= uart_pkg::ones_odd(buf_data) ^ par_odd;
            tx_shift_busy_flag_q     <= 1'b1;
            tx_state_q <= uart_pkg::TX_START;
          end
        end
        uart_pkg::TX_START: begin
          if (bit_tick) begin
            serial_q   <= 1'b0;       // start bit
            tx_idx_q   <= 3'h0;
            tx_state_q <= uart_pkg::TX_DATA;
          end
        end
        uart_pkg::TX_DATA: begin
          if (bit_tick) begin
            serial_q <= tx_shift_q[tx_idx_q];
            tx_idx_q <= tx_idx_q + 3'h1;
            if (tx_idx_q == last_idx) begin
              tx_state_q <= par_en ? uart_pkg::TX_PARITY : uart_pkg::TX_STOP;
              tx_idx_q   <= 3'h0;
            end
          end
        end
        uart_pkg::TX_PARITY: begin
          if (bit_tick) begin
            serial_q   <= tx_par_q;
            tx_state_q <= uart_pkg::TX_STOP;
          end
        end
        uart_pkg::TX_STOP: begin
          if (bit_tick) begin
            serial_q <= 1'b1;
            tx_idx_q <= tx_idx_q + 3'h1;
            if (tx_idx_q == n_stop) begin
              tx_shift_busy_flag_q     <= 1'b0;
              tx_state_q <= uart_pkg::TX_IDLE;
            end
          end
        end
        default: tx_state_q <= uart_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive pin synchroniser and framing
  // ----------------------------------------------------------------
  logic       rx_meta_q;   // first stage, read only by rx_sync_q
  logic       rx_sync_q;   // synchronised line
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_perr;
  logic       rx_ferr;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= i_serial_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  uart_rx_frame u_rx (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_tick16  (tick16_q),
    .i_enable  (en_q),
    .i_rxd     (rx_sync_q),
    .i_eight   (eight),
    .i_par_en  (par_en),
    .i_par_odd (par_odd),
    .o_done    (rx_done),
    .o_data    (rx_data),
    .o_par_err (rx_perr),
    .o_frm_err (rx_ferr)
  );

  // ----------------------------------------------------------------
  // two-entry receive queue and error flags
  // ----------------------------------------------------------------
  logic [7:0] mem_q [0:1]; // queue storage
  logic       rptr_q;      // oldest entry
  logic [1:0] cnt_q;       // entries held
  logic       perr_q;      // parity_error_flag
  logic       ferr_q;      // framing_error_flag
  logic       oerr_q;      // overrun_flag
  logic [7:0] rdata_q;     // read data register
  logic       level_q;     // queue full with rx_irq_threshold_bit set, else queue not empty

  wire       pop     = rd_rxbyte && (cnt_q != 2'h0);
  wire       accept  = rx_done && ((cnt_q != 2'h2) || pop);
  wire       ovr_set = rx_done && !accept;
  wire       wr_idx  = rptr_q ^ cnt_q[0];
  wire [1:0] cnt_d   = cnt_q + {1'b0, accept} - {1'b0, pop};
  wire       level_d = rx_irq_threshold_bit_d ? (cnt_d == 2'h2) : (cnt_d != 2'h0);
  wire [7:0] status  = {tx_done_flag_q, ferr_q, perr_q, oerr_q,
                        cnt_q == 2'h2, tx_shift_busy_flag_q, cnt_q != 2'h0, tx_buffer_empty_flag_q};
  wire [7:0] rd_mux  = (i_addr == `UART_ADDR_STATUS)  ? status :
                       (i_addr == `UART_ADDR_RXBYTE)  ? mem_q[rptr_q] :
                       (i_addr == `UART_ADDR_FORMAT)  ? {4'h0, fmt_q} :
                       (i_addr == `UART_ADDR_CONTROL) ? {6'h00, rx_irq_threshold_bit_q, en_q} : 8'h00;

  // queue pointers; an empty read leaves them alone
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
      rptr_q   <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (accept) begin
        mem_q[wr_idx] <= rx_data;
      end
      if (pop) begin
        rptr_q <= !rptr_q;
      end
      cnt_q <= cnt_d;
    end
  end

  // sticky errors; a new event beats a same-cycle clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      oerr_q <= 1'b0;
    end else begin
      perr_q <= (rx_done && rx_perr) ||
                (perr_q && !(wr_status && i_wdata[`ST_PAR_ERR]));
      ferr_q <= (rx_done && rx_ferr) ||
                (ferr_q && !(wr_status && i_wdata[`ST_FRM_ERR]));
      oerr_q <= ovr_set ||
                (oerr_q && !(wr_status && i_wdata[`ST_OVERRUN]));
    end
  end

  // read data and condition output, both registered
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 8'h00;
      level_q <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rd_mux : 8'h00;
      level_q <= level_d;
    end
  end

  assign o_rdata          = rdata_q;
  assign o_serial_out_pin = serial_q;
  assign o_rx_level       = level_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_tx_write_empty: assert property (wr_txbyte |=> !tx_buffer_empty_flag_q)
    else $error("buffer empty flag still set after byte write");
  a_tx_load_busy: assert property (tx_load && !wr_txbyte |=> tx_buffer_empty_flag_q && tx_shift_busy_flag_q)
    else $error("load did not set busy and empty");
  a_tx_done_set: assert property ($fell(tx_shift_busy_flag_q) |-> tx_done_flag_q)
    else $error("done flag missing after busy fell");
  a_tx_done_hold: assert property (tx_done_flag_q && !clr_tx_done_flag |=> tx_done_flag_q)
    else $error("done flag lost without clear");
  a_tx_start_low: assert property (
    (tx_state_q == uart_pkg::TX_START && bit_tick && en_q) ##1 en_q |->
      !o_serial_out_pin ##1 !o_serial_out_pin)
    else $error("start bit not driven low");
  a_rx_count_max: assert property (cnt_q <= 2'h2)
    else $error("receive queue exceeded two entries");
  a_rx_overrun: assert property (rx_done && cnt_q == 2'h2 && !pop |=> oerr_q && cnt_q == 2'h2)
    else $error("overrun not flagged or byte stored");
  a_rx_read_head: assert property (rd_rxbyte |=> o_rdata == $past(mem_q[rptr_q]))
    else $error("receive read did not return oldest byte");
  a_disable_flush: assert property ($fell(en_q) |-> tx_buffer_empty_flag_q)
    else $error("disable did not flush transmit buffer");
  a_rx_threshold: assert property (
    o_rx_level == (rx_irq_threshold_bit_q ? cnt_q == 2'h2 : cnt_q != 2'h0))
    else $error("receive threshold condition wrong");

  c_tx_frame:   cover property (tx_end);
  c_rx_full:    cover property (cnt_q == 2'h2);
  c_rx_overrun: cover property (ovr_set);
  c_rx_parity:  cover property (rx_done && rx_perr);

endmodule

// ===== dv/uart_line_partner.sv
// --------
// far-side serial device on the line
// --------
module uart_line_partner (
  input  wire logic i_clk,   // bench clock, bit = 16 clocks
  input  wire logic i_line,  // line from the design
  output logic      o_line   // line towards the design
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle line is high from time zero
  initial o_line = 1'b1;

  // drives n bits, bit 0 first, each held one full bit time
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_line <= b[i];
      repeat (15) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_line <= 1'b1;
  endtask

  // samples n bits at mid-bit; unsampled positions stay high
  task automatic capture(input int n, output logic [11:0] b);
    b = '1;
    wait (i_line === 1'b0);
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      b[i] = i_line;
      repeat (16) @(posedge i_clk);
    end
  endtask
endmodule

// ===== dv/uart_transfer_and_rx_errors_bench.sv
`include "uart_regs.svh"

module uart_transfer_and_rx_errors_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // --------
  // stimulus and design
  // --------
  logic        i_clk = 1'b0;  // 10 MHz
  logic        i_arst_n;
  logic [2:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [7:0]  o_rdata;
  logic        line_rx;       // partner to design
  logic        line_tx;       // design to partner
  logic        o_rx_level;
  logic [7:0]  v;             // last read value
  logic [11:0] eb;            // expected frame
  logic [11:0] sb;            // seen frame
  int          n;             // frame length in bits
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  // rows: expected line frame, then format nibble, then byte
  logic [23:0] rows [8] = '{24'hf4a0a5, 24'hf4a8a5, 24'he7843c, 24'hf7863c,
                            24'hd02c81, 24'hefce7e, 24'hf869c3, 24'heb4f5a};

  always #50 i_clk = ~i_clk;

  // a short tick keeps a bit at 16 clocks
  uart_core #(.TICK16_DIV(8'h01)) i_uart_core (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_in(line_rx),
    .o_serial_out_pin(line_tx), .o_rx_level(o_rx_level));

  uart_line_partner i_uart_line_partner (
    .i_clk(i_clk), .i_line(line_tx), .o_line(line_rx));

  // --------
  // helpers
  // --------
  // expected frame: start, data lsb first, parity, stop bits left high
  function automatic int mk(input logic [3:0] f, input logic [7:0] d,
                            output logic [11:0] b);
    int k;
    logic [7:0] m;
    m = f[3] ? d : {1'b0, d[6:0]};
    b = '1;
    b[0] = 1'b0;
    k = 1;
    for (int i = 0; i < (f[3] ? 8 : 7); i++) begin
      b[k] = m[i];
      k++;
    end
    if (f[2]) begin
      b[k] = ^m ^ f[1];
      k++;
    end
    return k + 1 + int'(f[0]);
  endfunction

  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [2:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic st(logic [7:0] e);
    rd(`UART_ADDR_STATUS);
    chk("status", v, e);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  // --------
  // main sequence
  // --------
  initial begin
    i_arst_n = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    st(8'h01);
    for (int k = 0; k < 8; k++) begin
      n = mk(rows[k][11:8], rows[k][7:0], sb);
      eb = rows[k][23:12];
      // format changes only while disabled
      wr(`UART_ADDR_CONTROL, 8'h00);
      wr(`UART_ADDR_FORMAT, {4'h0, rows[k][11:8]});
      wr(`UART_ADDR_CONTROL, 8'h01);
      wr(`UART_ADDR_TXBYTE, rows[k][7:0]);
      i_uart_line_partner.capture(n, sb);
      chk("tx frame", sb, eb);
      i_uart_line_partner.send(eb, n);
      rd(`UART_ADDR_RXBYTE);
      chk("rx byte", v, rows[k][11] ? rows[k][7:0] : {1'b0, rows[k][6:0]});
      st(8'h81);
      wr(`UART_ADDR_STATUS, 8'h80);
      st(8'h01);
    end
    // bad parity, then low first stop, then a third byte into a full queue
    i_uart_line_partner.send(eb ^ 12'h200, n);
    i_uart_line_partner.send(eb ^ 12'h406, n);
    st(8'h6b);
    i_uart_line_partner.send(eb, n);
    st(8'h7b);
    chk("level one", o_rx_level, 1'b1);
    wr(`UART_ADDR_CONTROL, 8'h03);
    rd(`UART_ADDR_RXBYTE);
    chk("oldest", v, 8'h5a);
    repeat (2) @(posedge i_clk);
    #1 chk("level two", o_rx_level, 1'b0);
    st(8'h73);
    rd(`UART_ADDR_RXBYTE);
    chk("second", v, 8'h59);
    wr(`UART_ADDR_STATUS, 8'h70);
    st(8'h01);
    // overwrite a waiting byte while disabled
    wr(`UART_ADDR_CONTROL, 8'h00);
    wr(`UART_ADDR_TXBYTE, 8'h11);
    wr(`UART_ADDR_TXBYTE, 8'h22);
    st(8'h00);
    wr(`UART_ADDR_CONTROL, 8'h01);
    n = mk(4'hf, 8'h22, eb);
    i_uart_line_partner.capture(n, sb);
    chk("overwrite", sb, eb);
    // capture returns after the last stop bit ends; busy fell eight clocks earlier
    repeat (8) @(posedge i_clk);
    st(8'h81);
    wr(`UART_ADDR_STATUS, 8'h80);
    wr(`UART_ADDR_TXBYTE, 8'h44);
    repeat (4) @(posedge i_clk);
    st(8'h05);
    wr(`UART_ADDR_TXBYTE, 8'h55);
    st(8'h04);
    // disabling mid-frame drops the waiting byte
    wr(`UART_ADDR_CONTROL, 8'h00);
    st(8'h81);
    end_sim();
  end
endmodule
